// ===== core/rssi_pwm_defs.svh
// Constants for the strength and pulse-width output block.
// Assumes a 50 MHz system clock and 32-bit word-aligned register access.
`ifndef RSSI_PWM_DEFS_SVH
`define RSSI_PWM_DEFS_SVH

// Clock and time base
`define CLK_PERIOD_NS        20
`define TICK_UNIT_NS         100000000
`define TICK_CYCLES          (`TICK_UNIT_NS / `CLK_PERIOD_NS)
`define PWM_PERIOD_NS        64000
`define PWM_PERIOD_CYCLES    (`PWM_PERIOD_NS / `CLK_PERIOD_NS)

// Step counts per period
`define PLAIN_STEPS          1023
`define STRENGTH_STEPS       445

// Strength to step mapping
`define STRENGTH_BASE_STEPS  107
`define STRENGTH_SLOPE_NUM   757
`define STRENGTH_SLOPE_DEN   100
`define STRENGTH_WEAK_SLOPE  4
`define STRENGTH_MIN_STEPS   5

// Register byte offsets
`define REG_FUNC_OFS         5'h00
`define REG_TIMERS_OFS       5'h04
`define REG_IADDR_OFS        5'h08
`define REG_LEVEL0_OFS       5'h0C
`define REG_LEVEL1_OFS       5'h10
`define REG_STATUS_OFS       5'h14

// Field positions
`define FUNC0_LSB            0
`define FUNC1_LSB            4
`define TIMEOUT_LSB          0
`define HOLD_LSB             8

// Reset values
`define FUNC0_RESET          2'h1
`define FUNC1_RESET          2'h0
`define TIMEOUT_RESET        8'hFF
`define HOLD_RESET           8'h28
`define HOLD_FOREVER         8'hFF
`define IADDR_RESET          16'hFFFF
`define LEVEL_RESET          10'h000

`endif

// ===== core/rssi_pwm_pkg.sv
// Types shared by the strength and pulse-width output block.
// Assumes nothing beyond the constants header.
package rssi_pwm_pkg;

	typedef enum logic [1:0]
	{
		FUNC_OFF      = 2'b00,
		FUNC_STRENGTH = 2'b01,
		FUNC_PLAIN    = 2'b10
	} func_e;

	typedef enum logic
	{
		BUS_IDLE   = 1'b0,
		BUS_ANSWER = 1'b1
	} bus_state_e;

endpackage : rssi_pwm_pkg

// ===== core/pwm_channel.sv
// One pulse-width generator with a fixed step count per fixed period.
// Assumes a level between 0 and STEPS; STEPS gives a steady high output.
`timescale 1ns/1ps
module pwm_channel #(
	parameter int unsigned STEPS         = 1023,
	parameter int unsigned PERIOD_CYCLES = 3200,
	parameter int unsigned LEVEL_W       = 10
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// Duty level and waveform
	input  wire logic [LEVEL_W-1:0] level,
	output logic                    pwm
);

	localparam int unsigned ACC_W = $clog2(PERIOD_CYCLES + STEPS) + 1;
	localparam int unsigned CNT_W = $clog2(STEPS + 1);
	localparam logic [ACC_W-1:0] ACC_ADD  = ACC_W'(STEPS);
	localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(PERIOD_CYCLES);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STEPS - 1);

	if (STEPS < 2 || STEPS > PERIOD_CYCLES || STEPS >= (1 << LEVEL_W) + 1)
	begin : bad_param
		$error("pwm_channel: step count does not fit period or level width");
	end

	logic [ACC_W-1:0] acc_q;
	logic [ACC_W-1:0] acc_sum;
	logic [ACC_W-1:0] acc_d;
	logic             step;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             pwm_d;

	// Fractional divider: STEPS enables per PERIOD_CYCLES clocks
	assign acc_sum = acc_q + ACC_ADD;
	assign step    = (acc_sum >= ACC_WRAP);
	assign acc_d   = step ? acc_sum - ACC_WRAP : acc_sum;
	assign cnt_d   = !step ? cnt_q : (cnt_q == CNT_LAST) ? '0 : cnt_q + 1'b1;
	assign pwm_d   = ({1'b0, cnt_q} < (LEVEL_W + 1)'(level));

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			acc_q <= '0;
			cnt_q <= '0;
			pwm   <= 1'b0;
		end
		else
		begin
			acc_q <= acc_d;
			cnt_q <= cnt_d;
			pwm   <= pwm_d;
		end
	end

endmodule : pwm_channel

// ===== core/rssi_pwm_output_control.sv
// Two pulse-width outputs: strength display, plain level and remote line passing.
// Assumes an Avalon-MM master, and a radio receiver that flags each packet for one cycle.
//
// Contract
// - Channel 0 function select 0..2: off, strength, plain; resets to strength.
// - Channel 1 function select 0..2: off, unused, plain; resets to off.
// - Matching sender address passes remote analog sample 0 to channel 0.
// - Matching sender address passes remote analog sample 1 to channel 1.
// - One shared output timeout, 0..0xFF times 100 ms, default 0xFF.
// - Non-zero passed level starts timeout; on expiry output forced to zero.
// - Every valid sample packet restarts the output timeout; here only packets from the matching sender address restart it.
// - Strength hold setting 0..0xFF times 100 ms, default 0x28.
// - Strength display uses 445 steps per period, about 144 ns each.
// - Duty 0 inactive, 1 to 24 weak, 24 to 100 percent stronger.
// - 10, 20, 30 dB above sensitivity give 41, 58, 75 percent.
// - Non-zero hold shows last strength; low after hold without packets.
// - Strength output low from power-up until the first packet.
// - Hold setting 0xFF never times out; shows last packet forever.
// - Plain mode uses 64 us period, 0x03FF steps, 0x01FF half duty.
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "rssi_pwm_defs.svh"
module rssi_pwm_output_control #(
	parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
	parameter int unsigned ADDR_W      = 16,
	parameter int unsigned SAMPLE_W    = 10
) (
	// Clock and reset
	input  wire logic                CLK,
	input  wire logic                RST,
	// Avalon-MM register slave
	input  wire logic [4:0]          AVS_ADDRESS,
	input  wire logic                AVS_READ,
	input  wire logic                AVS_WRITE,
	input  wire logic [31:0]         AVS_WRITEDATA,
	input  wire logic [3:0]          AVS_BYTEENABLE,
	output logic      [31:0]         AVS_READDATA,
	output logic                     AVS_WAITREQUEST,
	// Received packet events
	input  wire logic                PKT_VALID,
	input  wire logic [7:0]          PKT_STRENGTH_DB,
	input  wire logic                PKT_IO_VALID,
	input  wire logic [ADDR_W-1:0]   PKT_SRC_ADDR,
	input  wire logic [SAMPLE_W-1:0] REMOTE_ANALOG_IN_ZERO,
	input  wire logic [SAMPLE_W-1:0] REMOTE_ANALOG_IN_ONE,
	// Pulse outputs
	output logic                     PULSE_OUT_ZERO,
	output logic                     PULSE_OUT_ONE,
	// Function selectors, for observation
	output rssi_pwm_pkg::func_e      CHAN0_FUNCTION_SELECT,
	output rssi_pwm_pkg::func_e      CHAN1_FUNCTION_SELECT
);
	import rssi_pwm_pkg::*;

	localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

	if (TICK_CYCLES < 1 || ADDR_W < 1 || ADDR_W > 16 || SAMPLE_W != 10)
	begin : bad_param
		$error("rssi_pwm_output_control: unsupported parameter value");
	end

	// Byte-lane merge of a write into a register word
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				res[8*i +: 8] = wd[8*i +: 8];
		end
		return res;
	endfunction : be_merge

	// Strength margin in dB to display steps
	function automatic logic [8:0] strength_steps(input logic [7:0] db);
		logic signed [17:0] dbx;
		logic signed [17:0] v;
		dbx = 18'(signed'(db));
		if (dbx >= 18'sd0)
			v = 18'sd`STRENGTH_BASE_STEPS + (dbx * 18'sd`STRENGTH_SLOPE_NUM) / 18'sd`STRENGTH_SLOPE_DEN;
		else
			v = 18'sd`STRENGTH_BASE_STEPS + dbx * 18'sd`STRENGTH_WEAK_SLOPE;
		if (v > 18'sd`STRENGTH_STEPS)
			v = 18'sd`STRENGTH_STEPS;
		if (v < 18'sd`STRENGTH_MIN_STEPS)
			v = 18'sd`STRENGTH_MIN_STEPS;
		return v[8:0];
	endfunction : strength_steps

	// Register state
	logic [1:0]          func0_q;
	logic [1:0]          func1_q;
	logic [7:0]          timeout_q;
	logic [7:0]          hold_q;
	logic [ADDR_W-1:0]   iaddr_q;
	logic [9:0]          level_q [2];
	bus_state_e          bus_q;
	logic [31:0]         rdata_q;

	// Bus decode
	logic                req;
	logic                wr_now;
	logic [31:0]         func_word;
	logic [31:0]         timers_word;
	logic [31:0]         iaddr_word;
	logic [31:0]         level_word [2];
	logic [31:0]         status_word;
	logic [31:0]         rd_mux;
	logic [31:0]         wr_func;
	logic [31:0]         wr_timers;
	logic [31:0]         wr_iaddr;
	logic [31:0]         wr_level [2];
	logic                hit_func;
	logic                hit_timers;
	logic                hit_iaddr;
	logic [1:0]          hit_level;

	assign req         = AVS_READ | AVS_WRITE;
	assign wr_now      = AVS_WRITE && (bus_q == BUS_ANSWER);
	assign hit_func    = (AVS_ADDRESS == `REG_FUNC_OFS);
	assign hit_timers  = (AVS_ADDRESS == `REG_TIMERS_OFS);
	assign hit_iaddr   = (AVS_ADDRESS == `REG_IADDR_OFS);
	assign hit_level   = {AVS_ADDRESS == `REG_LEVEL1_OFS, AVS_ADDRESS == `REG_LEVEL0_OFS};

	assign func_word   = 32'(func0_q) << `FUNC0_LSB | 32'(func1_q) << `FUNC1_LSB;
	assign timers_word = 32'(timeout_q) << `TIMEOUT_LSB | 32'(hold_q) << `HOLD_LSB;
	assign iaddr_word  = 32'(iaddr_q);
	assign wr_func     = be_merge(func_word, AVS_WRITEDATA, AVS_BYTEENABLE);
	assign wr_timers   = be_merge(timers_word, AVS_WRITEDATA, AVS_BYTEENABLE);
	assign wr_iaddr    = be_merge(iaddr_word, AVS_WRITEDATA, AVS_BYTEENABLE);

	// One wait cycle, then the answer
	assign AVS_WAITREQUEST = req && (bus_q == BUS_IDLE);
	assign AVS_READDATA    = rdata_q;

	// Shared 100 ms tick
	logic [TICK_W-1:0]   tick_cnt_q;
	logic                tick;

	assign tick = (tick_cnt_q == TICK_LAST);

	// Strength display state
	logic                shown_q;
	logic [7:0]          hold_cnt_q;
	logic [8:0]          str_level_q;
	logic [8:0]          str_duty;

	// Line passing state per channel
	logic                src_match;
	logic [SAMPLE_W-1:0] analog_in [2];
	logic [1:0]          pass_on_q;
	logic [1:0]          pass_run_q;
	logic [9:0]          pass_level_q [2];
	logic [7:0]          pass_cnt_q [2];
	logic [9:0]          plain_duty [2];
	logic [1:0]          plain_pwm;
	logic                str_pwm;

	assign src_match    = PKT_IO_VALID && (PKT_SRC_ADDR == iaddr_q);
	assign analog_in[0] = REMOTE_ANALOG_IN_ZERO;
	assign analog_in[1] = REMOTE_ANALOG_IN_ONE;

	for (genvar c = 0; c < 2; c++)
	begin : g_lw
		assign level_word[c] = 32'(level_q[c]);
		assign wr_level[c]   = be_merge(level_word[c], AVS_WRITEDATA, AVS_BYTEENABLE);
	end

	assign status_word = {7'h00, str_level_q, 1'b0, plain_duty[0], shown_q, pass_run_q, PULSE_OUT_ONE, PULSE_OUT_ZERO};
	assign rd_mux = hit_func     ? func_word :
	                hit_timers   ? timers_word :
	                hit_iaddr    ? iaddr_word :
	                hit_level[0] ? level_word[0] :
	                hit_level[1] ? level_word[1] :
	                (AVS_ADDRESS == `REG_STATUS_OFS) ? status_word : 32'h0000_0000;

	// Bus slave sequencing
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			bus_q   <= BUS_IDLE;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			bus_q   <= (req && bus_q == BUS_IDLE) ? BUS_ANSWER : BUS_IDLE;
			rdata_q <= (AVS_READ && bus_q == BUS_IDLE) ? rd_mux : rdata_q;
		end
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			func0_q   <= `FUNC0_RESET;
			func1_q   <= `FUNC1_RESET;
			timeout_q <= `TIMEOUT_RESET;
			hold_q    <= `HOLD_RESET;
			iaddr_q   <= ADDR_W'(`IADDR_RESET);
		end
		else if (wr_now)
		begin
			if (hit_func)
			begin
				func0_q <= wr_func[`FUNC0_LSB +: 2];
				func1_q <= wr_func[`FUNC1_LSB +: 2];
			end
			if (hit_timers)
			begin
				timeout_q <= wr_timers[`TIMEOUT_LSB +: 8];
				hold_q    <= wr_timers[`HOLD_LSB +: 8];
			end
			if (hit_iaddr)
				iaddr_q <= wr_iaddr[ADDR_W-1:0];
		end
	end

	assign CHAN0_FUNCTION_SELECT = (func0_q == 2'h1) ? FUNC_STRENGTH : (func0_q == 2'h2) ? FUNC_PLAIN : FUNC_OFF;
	assign CHAN1_FUNCTION_SELECT = (func1_q == 2'h2) ? FUNC_PLAIN : FUNC_OFF;

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			shown_q     <= 1'b0;
			hold_cnt_q  <= 8'h00;
			str_level_q <= 9'h000;
		end
		else if (PKT_VALID)
		begin
			str_level_q <= strength_steps(PKT_STRENGTH_DB);
			shown_q     <= (hold_q != 8'h00);
			hold_cnt_q  <= hold_q;
		end
		else if (hold_q == 8'h00)
			shown_q <= 1'b0;
		else if (tick && shown_q && hold_q != `HOLD_FOREVER)
		begin
			shown_q    <= (hold_cnt_q > 8'h01);
			hold_cnt_q <= hold_cnt_q - 8'h01;
		end
	end

	assign str_duty = shown_q ? str_level_q : 9'h000;

	for (genvar c = 0; c < 2; c++)
	begin : g_pass
		// Level register; a write hands the channel back to software unless a matching packet arrives in the same cycle
		always_ff @(posedge CLK or posedge RST)
		begin
			if (RST)
				level_q[c] <= `LEVEL_RESET;
			else if (wr_now && hit_level[c])
				level_q[c] <= wr_level[c][9:0];
		end

		always_ff @(posedge CLK or posedge RST)
		begin
			if (RST)
			begin
				pass_on_q[c]    <= 1'b0;
				pass_run_q[c]   <= 1'b0;
				pass_level_q[c] <= 10'h000;
				pass_cnt_q[c]   <= 8'h00;
			end
			else if (src_match)
			begin
				pass_on_q[c]    <= 1'b1;
				pass_level_q[c] <= analog_in[c];
				pass_run_q[c]   <= (analog_in[c] != 10'h000);
				pass_cnt_q[c]   <= timeout_q;
			end
			else if (wr_now && hit_level[c])
			begin
				pass_on_q[c]  <= 1'b0;
				pass_run_q[c] <= 1'b0;
			end
			else if (tick && pass_run_q[c])
			begin
				if (pass_cnt_q[c] == 8'h00)
				begin
					pass_run_q[c]   <= 1'b0;
					pass_level_q[c] <= 10'h000;
				end
				else
					pass_cnt_q[c] <= pass_cnt_q[c] - 8'h01;
			end
		end

		assign plain_duty[c] = pass_on_q[c] ? pass_level_q[c] : level_q[c];

		pwm_channel #(
			.STEPS         (`PLAIN_STEPS),
			.PERIOD_CYCLES (`PWM_PERIOD_CYCLES),
			.LEVEL_W       (10)
		) u_plain (
			.clk   (CLK),
			.rst   (RST),
			.level (plain_duty[c]),
			.pwm   (plain_pwm[c])
		);
	end

	pwm_channel #(
		.STEPS         (`STRENGTH_STEPS),
		.PERIOD_CYCLES (`PWM_PERIOD_CYCLES),
		.LEVEL_W       (9)
	) u_strength (
		.clk   (CLK),
		.rst   (RST),
		.level (str_duty),
		.pwm   (str_pwm)
	);

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			PULSE_OUT_ZERO <= 1'b0;
			PULSE_OUT_ONE  <= 1'b0;
		end
		else
		begin
			PULSE_OUT_ZERO <= (CHAN0_FUNCTION_SELECT == FUNC_STRENGTH) ? str_pwm :
			                  (CHAN0_FUNCTION_SELECT == FUNC_PLAIN) ? plain_pwm[0] : 1'b0;
			PULSE_OUT_ONE  <= (CHAN1_FUNCTION_SELECT == FUNC_PLAIN) ? plain_pwm[1] : 1'b0;
		end
	end

endmodule : rssi_pwm_output_control

// ===== tb/rssi_pwm_monitor.sv
// Concurrent checks on the strength and pulse-width output block.
// Assumes binding to the top module; sees its ports only.
`timescale 1ns/1ps
module rssi_pwm_monitor (
	// Clock and reset
	input wire logic                CLK,
	input wire logic                RST,
	// Register bus
	input wire logic [4:0]          AVS_ADDRESS,
	input wire logic                AVS_READ,
	input wire logic                AVS_WRITE,
	input wire logic [31:0]         AVS_WRITEDATA,
	input wire logic [3:0]          AVS_BYTEENABLE,
	input wire logic [31:0]         AVS_READDATA,
	input wire logic                AVS_WAITREQUEST,
	// Packets and pulses
	input wire logic                PKT_VALID,
	input wire logic                PKT_IO_VALID,
	input wire logic                PULSE_OUT_ZERO,
	input wire logic                PULSE_OUT_ONE,
	input rssi_pwm_pkg::func_e      CHAN0_FUNCTION_SELECT,
	input rssi_pwm_pkg::func_e      CHAN1_FUNCTION_SELECT
);
	import rssi_pwm_pkg::*;
	logic [7:0] hold_q;
	logic       seen_q;
	wire        func_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] && AVS_ADDRESS == 5'h00;
	wire        hold_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[1] && AVS_ADDRESS == 5'h04;
	wire [7:0]  hold_d  = hold_wr ? AVS_WRITEDATA[15:8] : hold_q;
	wire func_e dec0    = (AVS_WRITEDATA[1:0] == 2'h1) ? FUNC_STRENGTH :
		(AVS_WRITEDATA[1:0] == 2'h2) ? FUNC_PLAIN : FUNC_OFF;
	wire func_e dec1    = (AVS_WRITEDATA[5:4] == 2'h2) ? FUNC_PLAIN : FUNC_OFF;
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			hold_q <= 8'h28;
			seen_q <= 1'b0;
		end
		else
		begin
			hold_q <= hold_d;
			seen_q <= seen_q | PKT_VALID;
		end
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	a_one_wait_state: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
		else $error("waitrequest not one cycle");
	a_readdata_stands: assert property ($changed(AVS_READDATA) |-> $past(AVS_READ && AVS_WAITREQUEST))
		else $error("read data changed outside a read");
	a_sel0_follows: assert property (func_wr |=> CHAN0_FUNCTION_SELECT == $past(dec0))
		else $error("channel 0 select wrong");
	a_sel1_follows: assert property (func_wr |=> CHAN1_FUNCTION_SELECT == $past(dec1))
		else $error("channel 1 select wrong");
	a_sel1_no_strength: assert property (CHAN1_FUNCTION_SELECT != FUNC_STRENGTH)
		else $error("channel 1 in strength mode");
	a_off_quiet_zero: assert property ((CHAN0_FUNCTION_SELECT == FUNC_OFF) [*4] |-> !PULSE_OUT_ZERO)
		else $error("channel 0 active while off");
	a_off_quiet_one: assert property ((CHAN1_FUNCTION_SELECT == FUNC_OFF) [*4] |-> !PULSE_OUT_ONE)
		else $error("channel 1 active while off");
	a_dark_before_packet: assert property ((!seen_q && CHAN0_FUNCTION_SELECT == FUNC_STRENGTH) [*4] |-> !PULSE_OUT_ZERO)
		else $error("strength shown before any packet");
	a_hold_zero_dark: assert property ((hold_q == 8'h00 && CHAN0_FUNCTION_SELECT == FUNC_STRENGTH) [*8] |-> !PULSE_OUT_ZERO)
		else $error("strength shown with hold zero");
	c_func_write: cover property (func_wr);
	c_io_packet: cover property (PKT_IO_VALID);
	c_pulse_rise: cover property ($rose(PULSE_OUT_ZERO));
endmodule : rssi_pwm_monitor

bind rssi_pwm_output_control rssi_pwm_monitor u_mon (.CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .PKT_VALID(PKT_VALID),
	.PKT_IO_VALID(PKT_IO_VALID), .PULSE_OUT_ZERO(PULSE_OUT_ZERO), .PULSE_OUT_ONE(PULSE_OUT_ONE),
	.CHAN0_FUNCTION_SELECT(CHAN0_FUNCTION_SELECT), .CHAN1_FUNCTION_SELECT(CHAN1_FUNCTION_SELECT));

// ===== tb/duty_meter.sv
// Filter model on the two pulse pins: counts high cycles over one period.
// Assumes go is a one-cycle pulse in the clock domain.
`timescale 1ns/1ps
module duty_meter (
	// Clock and control
	input  wire logic clk,
	input  wire logic go,
	// Pulse pins
	input  wire logic pin0,
	input  wire logic pin1,
	// High cycles in the window
	output int        hi0,
	output int        hi1,
	output logic      done
);
	int n;
	initial done = 1'b1;
	always @(posedge clk)
	begin
		if (go)
		begin
			n <= 0;
			hi0 <= 0;
			hi1 <= 0;
			done <= 1'b0;
		end
		else if (!done)
		begin
			hi0 <= hi0 + int'(pin0);
			hi1 <= hi1 + int'(pin1);
			n <= n + 1;
			done <= (n == 3199);
		end
	end
endmodule : duty_meter

// ===== tb/tb_top.sv
// Testbench for the strength and pulse-width output block.
// Assumes the duty meter as far side and a shortened 100 ms tick.
`timescale 1ns/1ps
module tb_top;
	import rssi_pwm_pkg::*;
	localparam int TCK = 400;
	logic CLK = 0, RST = 1, AVS_READ = 0, AVS_WRITE = 0, PKT_VALID = 0, PKT_IO_VALID = 0, go = 0;
	logic [4:0]  AVS_ADDRESS = 0;
	logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA, rd;
	logic [7:0]  PKT_STRENGTH_DB = 0;
	logic [15:0] PKT_SRC_ADDR = 0;
	logic [9:0]  REMOTE_ANALOG_IN_ZERO = 0, REMOTE_ANALOG_IN_ONE = 0, v0, v1;
	logic        AVS_WAITREQUEST, PULSE_OUT_ZERO, PULSE_OUT_ONE, done;
	func_e       CHAN0_FUNCTION_SELECT, CHAN1_FUNCTION_SELECT;
	int          fail_count = 0, tests_run = 0, h0, h1, i, db;
	logic [31:0] seed = 32'h3c57_e057;
	logic [4:0]  ra [6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h18};
	logic [31:0] rv [6] = '{32'h0000_0001, 32'h0000_28FF, 32'h0000_FFFF, 32'h0, 32'h0, 32'h0};
	always #10 CLK = ~CLK;
	rssi_pwm_output_control #(.TICK_CYCLES(TCK)) uut (.CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .PKT_VALID(PKT_VALID),
		.PKT_STRENGTH_DB(PKT_STRENGTH_DB), .PKT_IO_VALID(PKT_IO_VALID), .PKT_SRC_ADDR(PKT_SRC_ADDR),
		.REMOTE_ANALOG_IN_ZERO(REMOTE_ANALOG_IN_ZERO), .REMOTE_ANALOG_IN_ONE(REMOTE_ANALOG_IN_ONE),
		.PULSE_OUT_ZERO(PULSE_OUT_ZERO), .PULSE_OUT_ONE(PULSE_OUT_ONE),
		.CHAN0_FUNCTION_SELECT(CHAN0_FUNCTION_SELECT), .CHAN1_FUNCTION_SELECT(CHAN1_FUNCTION_SELECT));
	duty_meter far (.clk(CLK), .go(go), .pin0(PULSE_OUT_ZERO), .pin1(PULSE_OUT_ONE), .hi0(h0), .hi1(h1),
		.done(done));
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	// Strength model: steps of 445, then high cycles in 3200
	function int sexp(int d);
		int s;
		s = (d >= 0) ? 107 + d * 757 / 100 : 107 + 4 * d;
		s = (s < 5) ? 5 : (s > 445) ? 445 : s;
		return s * 3200 / 445;
	endfunction : sexp
	task conclude();
		$display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	task chk(input logic [31:0] g, input logic [31:0] e, input int tol);
		int d;
		d = int'(g) - int'(e);
		tests_run++;
		if ($isunknown(g) || (tol == 0 && g !== e) || d > tol || d < -tol)
		begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
		int k;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= wd;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		for (k = 0; k < 50; k++)
		begin
			@(posedge CLK);
			if (AVS_WAITREQUEST === 1'b0)
				break;
		end
		rd = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		@(posedge CLK);
		if (k == 50)
		begin
			fail_count++;
			conclude();
		end
	endtask : bus
	task pkt(input logic io, input int d, input logic [15:0] ad, input logic [9:0] a0, input logic [9:0] a1);
		PKT_VALID <= !io;
		PKT_IO_VALID <= io;
		PKT_STRENGTH_DB <= d[7:0];
		PKT_SRC_ADDR <= ad;
		REMOTE_ANALOG_IN_ZERO <= a0;
		REMOTE_ANALOG_IN_ONE <= a1;
		@(posedge CLK);
		PKT_VALID <= 1'b0;
		PKT_IO_VALID <= 1'b0;
		@(posedge CLK);
	endtask : pkt
	task meas();
		int k;
		go <= 1'b1;
		@(posedge CLK);
		go <= 1'b0;
		@(posedge CLK);
		for (k = 0; k < 4000 && done !== 1'b1; k++)
			@(posedge CLK);
		if (k == 4000)
		begin
			fail_count++;
			conclude();
		end
	endtask : meas
	task wt(input int n);
		repeat (n * TCK) @(posedge CLK);
	endtask : wt
	initial
	begin
		repeat (6) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		for (i = 0; i < 6; i++)
		begin
			bus(1'b0, ra[i], 32'h0);
			chk(rd, rv[i], 0);
		end
		meas();
		chk(h0, 0, 0);
		bus(1'b1, 5'h04, 32'h0000_10FF);
		for (i = 0; i < 4; i++)
		begin
			db = (i < 3) ? 10 * (i + 1) : int'(xs() % 36) - 12;
			pkt(1'b0, db, 16'h0, 10'h0, 10'h0);
			meas();
			chk(h0, sexp(db), 12);
		end
		wt(10);
		meas();
		chk(h0, 0, 0);
		bus(1'b1, 5'h04, 32'h0000_FFFF);
		pkt(1'b0, 20, 16'h0, 10'h0, 10'h0);
		wt(20);
		meas();
		chk(h0, sexp(20), 12);
		bus(1'b1, 5'h04, 32'h0000_00FF);
		pkt(1'b0, 30, 16'h0, 10'h0, 10'h0);
		meas();
		chk(h0, 0, 0);
		bus(1'b1, 5'h00, 32'h0000_0022);
		chk(CHAN1_FUNCTION_SELECT, FUNC_PLAIN, 0);
		bus(1'b1, 5'h0C, 32'h0000_01FF);
		bus(1'b1, 5'h10, 32'h0000_03FF);
		meas();
		chk(h0, 511 * 3200 / 1023, 8);
		chk(h1, 3200, 0);
		bus(1'b1, 5'h0C, 32'h0);
		meas();
		chk(h0, 0, 0);
		bus(1'b1, 5'h08, 32'h0000_1234);
		bus(1'b1, 5'h04, 32'h0000_1020);
		v0 = 10'(xs()) | 10'h010;
		v1 = 10'(xs()) | 10'h010;
		pkt(1'b1, 0, 16'h1234, v0, v1);
		meas();
		chk(h0, v0 * 3200 / 1023, 8);
		chk(h1, v1 * 3200 / 1023, 8);
		pkt(1'b1, 0, 16'(xs()) | 16'h8000, ~v0, ~v1);
		meas();
		chk(h0, v0 * 3200 / 1023, 8);
		wt(4);
		pkt(1'b1, 0, 16'h1234, v0, v1);
		wt(20);
		meas();
		chk(h1, v1 * 3200 / 1023, 8);
		wt(8);
		meas();
		chk(h0 + h1, 0, 0);
		bus(1'b0, 5'h14, 32'h0);
		chk(rd, 32'h014E_0000, 0);
		bus(1'b1, 5'h00, 32'h0000_0013);
		chk(CHAN0_FUNCTION_SELECT, FUNC_OFF, 0);
		chk(CHAN1_FUNCTION_SELECT, FUNC_OFF, 0);
		repeat (8) @(posedge CLK);
		conclude();
	end
endmodule : tb_top
